// ==== design/homing_without_index.sv ====
// Summary of operation
// - Edge limit 0 disables edge monitoring; positive sets maximum.
// - Edge not found within enabled limit cancels homing with error.
// - Overrun limit 0 disables check; positive sets search distance.
// - After overrun, switch must return within the limit, else cancel.
// - Method codes 17, 18 and 23 to 30 select homing without index pulse.
// - Move to selected switch first, then to distance from edge.
// - After leaving switch, move by offset; target is reference point.
// - Offset applies only to methods without index pulse search.
// - Approach toward switch runs at switch search speed.
// - Edge move and offset move run at leave-switch speed.
// - Passing through switch returns at leave-switch speed before edge.
// - Code 17 homes to negative limit switch with edge offset.
// - Codes 27 to 30 home to reference switch, negative search.
// - Code 18 homes to positive limit; 23 to 26 reference, positive.
// - Both speeds are clamped to the maximum ramp speed.
// - On success, load reference position value at the reference point.
`timescale 1ns/10ps
`default_nettype none
module homing_without_index
	import homing_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	// Parameter access
	input  wire logic [15:0]        par_addr_i,
	input  wire logic [31:0]        par_wdata_i,
	input  wire logic               par_wr_i,
	input  wire logic               par_rd_i,
	output logic      [31:0]        par_rdata_o,
	// Homing configuration
	input  wire logic [15:0]        homing_method_select_i,
	input  wire logic [15:0]        switch_search_speed_i,
	input  wire logic [15:0]        leave_switch_speed_i,
	input  wire logic [15:0]        max_ramp_speed_i,
	input  wire logic signed [31:0] reference_position_value_i,
	input  wire logic               start_i,
	// Switch pins
	input  wire logic               negative_limit_switch_i,
	input  wire logic               positive_limit_switch_i,
	input  wire logic               reference_switch_i,
	// Motor axis
	input  wire logic signed [31:0] pos_i,
	input  wire logic               motor_still_i,
	output logic signed [16:0]      vel_o,
	output logic                    set_pos_o,
	output logic signed [31:0]      set_pos_val_o,
	// Status
	output logic                    busy_o,
	output logic                    homed_o,
	output logic                    err_o
);

	typedef struct packed {
		home_state_e        st;
		logic               search_neg;
		logic               edge_neg;
		logic               is_ref;
		logic               err;
		logic               homed;
		logic               set_pos;
		logic signed [31:0] set_val;
		logic signed [31:0] mark;
		logic signed [31:0] target;
		logic signed [16:0] vel;
		logic [31:0]        edge_lim;
		logic [31:0]        offset;
		logic [31:0]        ovr_lim;
		logic [31:0]        rdata;
	} home_s;

	home_s cur_ff;
	home_s nxt_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	logic [2:0]  sw_sync;
	logic        sw_act;
	logic [15:0] m;
	logic        m_valid;
	logic [15:0] spd_search;
	logic [15:0] spd_leave;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic over_dist(input logic signed [31:0] a,
		input logic signed [31:0] b, input logic [31:0] lim);
		logic signed [31:0] d;
		d = a - b;
		return (lim != 32'h0) && ($unsigned((d < 0) ? -d : d) > lim);
	endfunction

	function automatic logic [15:0] clamp_spd(input logic [15:0] s,
		input logic [15:0] mx);
		return (s > mx) ? mx : s;
	endfunction

	function automatic logic signed [16:0] mk_vel(input logic [15:0] s,
		input logic neg);
		logic signed [16:0] v;
		v = $signed({1'b0, s});
		return neg ? -v : v;
	endfunction

	// ****************************************
	// Switch synchroniser
	// ****************************************
	switch_sync #(
		.WIDTH (3)
	) u_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.pin_i  ({reference_switch_i, positive_limit_switch_i,
			negative_limit_switch_i}),
		.sync_o (sw_sync)
	);

	assign m          = homing_method_select_i;
	assign m_valid    = (m == M_NEG_LIMIT) || (m == M_POS_LIMIT) ||
		((m >= M_REFP_LO) && (m <= M_REFN_HI));
	assign spd_search = clamp_spd(switch_search_speed_i,
		max_ramp_speed_i);
	assign spd_leave  = clamp_spd(leave_switch_speed_i,
		max_ramp_speed_i);
	// Selected switch
	assign sw_act = cur_ff.is_ref ? sw_sync[2] :
		(cur_ff.search_neg ? sw_sync[0] : sw_sync[1]);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.set_pos = 1'b0;
		// Parameter writes, negative values refused
		if (par_wr_i && !par_wdata_i[31]) begin
			unique case (par_addr_i)
				ADDR_EDGE_LIM: nxt_ff.edge_lim = par_wdata_i;
				ADDR_OVR_LIM:  nxt_ff.ovr_lim = par_wdata_i;
				ADDR_OFFSET: begin
					if (par_wdata_i >= OFFSET_MIN) begin
						nxt_ff.offset = par_wdata_i;
					end
				end
				default: ;
			endcase
		end
		if (par_rd_i) begin
			unique case (par_addr_i)
				ADDR_EDGE_LIM: nxt_ff.rdata = cur_ff.edge_lim;
				ADDR_OVR_LIM:  nxt_ff.rdata = cur_ff.ovr_lim;
				ADDR_OFFSET:   nxt_ff.rdata = cur_ff.offset;
				ADDR_STATUS: begin
					nxt_ff.rdata = 32'h0;
					nxt_ff.rdata[STAT_ERR_BIT] = cur_ff.err;
					nxt_ff.rdata[STAT_HOMED_BIT] = cur_ff.homed;
					nxt_ff.rdata[STAT_BUSY_BIT] = (cur_ff.st != ST_IDLE);
				end
				default: nxt_ff.rdata = 32'h0;
			endcase
		end
		unique case (cur_ff.st)
			ST_IDLE: begin
				if (start_i) begin
					nxt_ff.homed = 1'b0;
					if (m_valid) begin
						nxt_ff.err = 1'b0;
						nxt_ff.is_ref = (m >= M_REFP_LO);
						nxt_ff.search_neg = (m == M_NEG_LIMIT) || (m >= M_REFN_LO);
						// Limit switches always back out; ref inverts on even codes
						if (m < M_REFP_LO) begin
							nxt_ff.edge_neg = (m == M_POS_LIMIT);
						end else begin
							nxt_ff.edge_neg = (m >= M_REFN_LO) ^ ~m[0];
						end
						nxt_ff.st = ST_SEARCH;
					end else begin
						nxt_ff.err = 1'b1;
					end
				end
			end
			ST_SEARCH: begin
				if (sw_act) begin
					nxt_ff.st = ST_SETTLE;
				end
			end
			// Wait for the axis to stop, then check for overrun
			ST_SETTLE: begin
				if (motor_still_i) begin
					nxt_ff.mark = pos_i;
					nxt_ff.st = sw_act ? ST_EDGE : ST_RETURN;
				end
			end
			ST_RETURN: begin
				if (sw_act) begin
					nxt_ff.mark = pos_i;
					nxt_ff.st = ST_EDGE;
				end else if (over_dist(pos_i, cur_ff.mark, cur_ff.ovr_lim)) begin
					nxt_ff.st = ST_IDLE;
					nxt_ff.err = 1'b1;
				end
			end
			ST_EDGE: begin
				if (!sw_act) begin
					nxt_ff.target = cur_ff.edge_neg ? pos_i - $signed(cur_ff.offset) :
						pos_i + $signed(cur_ff.offset);
					nxt_ff.st = ST_OFFSET;
				end else if (over_dist(pos_i, cur_ff.mark, cur_ff.edge_lim)) begin
					nxt_ff.st = ST_IDLE;
					nxt_ff.err = 1'b1;
				end
			end
			ST_OFFSET: begin
				if (cur_ff.edge_neg ? (pos_i <= cur_ff.target) :
					(pos_i >= cur_ff.target)) begin
					nxt_ff.st = ST_IDLE;
					nxt_ff.homed = 1'b1;
					nxt_ff.set_pos = 1'b1;
					nxt_ff.set_val = reference_position_value_i;
				end
			end
			default: nxt_ff.st = ST_IDLE;
		endcase
		// Speed follows the next state so it lines up with it
		unique case (nxt_ff.st)
			ST_SEARCH: nxt_ff.vel = mk_vel(spd_search, nxt_ff.search_neg);
			ST_RETURN: nxt_ff.vel = mk_vel(spd_leave, ~nxt_ff.search_neg);
			ST_EDGE,
			ST_OFFSET: nxt_ff.vel = mk_vel(spd_leave, nxt_ff.edge_neg);
			default:   nxt_ff.vel = 17'sh0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cur_ff <= '{st: ST_IDLE, edge_lim: RST_EDGE_LIM, offset: RST_OFFSET,
				ovr_lim: RST_OVR_LIM, default: '0};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign par_rdata_o   = cur_ff.rdata;
	assign vel_o         = cur_ff.vel;
	assign set_pos_o     = cur_ff.set_pos;
	assign set_pos_val_o = cur_ff.set_val;
	assign busy_o        = (cur_ff.st != ST_IDLE);
	assign homed_o       = cur_ff.homed;
	assign err_o         = cur_ff.err;

	// ****************************************
	// Checks
	// ****************************************
	a_edge_no_mon: assert property (
		(cur_ff.st == ST_EDGE && cur_ff.edge_lim == 32'h0 && sw_act)
		|=> cur_ff.st == ST_EDGE && !cur_ff.err)
		else $error("edge search left without monitoring cause");
	a_edge_cancel: assert property (
		(cur_ff.st == ST_EDGE && sw_act &&
		over_dist(pos_i, cur_ff.mark, cur_ff.edge_lim))
		|=> cur_ff.st == ST_IDLE && cur_ff.err && vel_o == 17'sh0)
		else $error("edge search overrun not cancelled");
	a_overrun_cancel: assert property (
		(cur_ff.st == ST_RETURN && !sw_act &&
		over_dist(pos_i, cur_ff.mark, cur_ff.ovr_lim))
		|=> cur_ff.err && !homed_o && !busy_o)
		else $error("overrun search not cancelled");
	a_method_reject: assert property (
		(cur_ff.st == ST_IDLE && start_i && !m_valid)
		|=> err_o && !busy_o ##1 !busy_o)
		else $error("illegal method started");
	a_search_speed: assert property (
		cur_ff.st == ST_SEARCH |-> vel_o == mk_vel(clamp_spd(
		$past(switch_search_speed_i), $past(max_ramp_speed_i)), cur_ff.search_neg))
		else $error("search speed wrong");
	a_leave_speed: assert property (
		(cur_ff.st == ST_EDGE || cur_ff.st == ST_OFFSET) |->
		(vel_o < 0) == cur_ff.edge_neg && vel_o != 17'sh0 ||
		$past(leave_switch_speed_i) == 16'h0 || $past(max_ramp_speed_i) == 16'h0)
		else $error("leave speed direction wrong");
	a_return_dir: assert property (
		$rose(cur_ff.st == ST_RETURN) |-> $past(cur_ff.st) == ST_SETTLE &&
		(vel_o <= 0) == !cur_ff.search_neg)
		else $error("return entered wrongly");
	a_ref_load: assert property (
		(cur_ff.st == ST_OFFSET && nxt_ff.st == ST_IDLE)
		|=> set_pos_o && homed_o && set_pos_val_o ==
		$past(reference_position_value_i) ##1 !set_pos_o)
		else $error("reference value not loaded");
	a_cancel_unref: assert property (
		$rose(err_o) |-> !homed_o && vel_o == 17'sh0 && !busy_o)
		else $error("cancel left axis moving or referenced");
endmodule
`default_nettype wire

// ==== design/homing_pkg.sv ====
package homing_pkg;

	// ****************************************
	// Parameter addresses
	// ****************************************
	localparam logic [15:0] ADDR_EDGE_LIM = 16'h280c;
	localparam logic [15:0] ADDR_OFFSET   = 16'h280e;
	localparam logic [15:0] ADDR_OVR_LIM  = 16'h281a;
	localparam logic [15:0] ADDR_STATUS   = 16'h2830;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [31:0] RST_EDGE_LIM = 32'h0000_0000;
	localparam logic [31:0] RST_OFFSET   = 32'h0000_00c8;
	localparam logic [31:0] RST_OVR_LIM  = 32'h0000_0000;
	localparam logic [31:0] OFFSET_MIN   = 32'h0000_0001;

	// ****************************************
	// Status word bit positions
	// ****************************************
	localparam int STAT_ERR_BIT   = 0;
	localparam int STAT_HOMED_BIT = 1;
	localparam int STAT_BUSY_BIT  = 2;

	// ****************************************
	// Method codes
	// ****************************************
	localparam logic [15:0] M_NEG_LIMIT = 16'h0011;
	localparam logic [15:0] M_POS_LIMIT = 16'h0012;
	localparam logic [15:0] M_REFP_LO   = 16'h0017;
	localparam logic [15:0] M_REFP_HI   = 16'h001a;
	localparam logic [15:0] M_REFN_LO   = 16'h001b;
	localparam logic [15:0] M_REFN_HI   = 16'h001e;

	// ****************************************
	// Synchroniser depth
	// ****************************************
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SEARCH = 3'b001,
		ST_SETTLE = 3'b010,
		ST_RETURN = 3'b011,
		ST_EDGE   = 3'b100,
		ST_OFFSET = 3'b101
	} home_state_e;

endpackage

// ==== design/switch_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module switch_sync
	import homing_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// Raw pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_s;

	sync_s cur_ff;
	sync_s nxt_ff;

	always_comb begin
		nxt_ff.meta = pin_i;
		nxt_ff.sync = cur_ff.meta;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign sync_o = cur_ff.sync;

endmodule
`default_nettype wire

// ==== verif/axis_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module axis_model #(
	parameter int LIM    = 1000,
	parameter int REF_LO = 45,
	parameter int REF_HI = 60
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	// Velocity command and repositioning
	input  wire logic signed [16:0] vel_i,
	input  wire logic               place_i,
	// Axis feedback
	output logic signed [31:0]      pos_o,
	output logic                    still_o,
	// Switch pins, high while active
	output logic                    neg_sw_o,
	output logic                    pos_sw_o,
	output logic                    ref_sw_o
);
	logic signed [31:0] mag;

	// Axis follows the command with no ramp
	always_ff @(posedge clk_i) begin
		if (!rstn_i || place_i) begin
			pos_o   <= '0;
			still_o <= 1'b1;
		end else begin
			pos_o   <= pos_o + 32'(vel_i);
			still_o <= (vel_i == '0);
		end
	end

	// Narrow cam on both sides, fast search overruns it
	assign mag      = pos_o < 0 ? -pos_o : pos_o;
	assign neg_sw_o = pos_o <= -LIM;
	assign pos_sw_o = pos_o >= LIM;
	assign ref_sw_o = mag >= REF_LO && mag <= REF_HI;
endmodule
`default_nettype wire

// ==== verif/test_homing_without_index.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_homing_without_index import homing_pkg::*;;
	logic               clk_i = 1'b0;
	logic               rstn_i = 1'b0;
	logic [15:0]        addr = '0;
	logic [31:0]        wdata = '0;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic [31:0]        par_rdata_o;
	logic [15:0]        meth = '0;
	logic signed [31:0] refval = 32'sh0000_1234;
	logic               start = 1'b0;
	logic               place = 1'b0;
	logic signed [31:0] pos;
	logic               still, nsw, psw, rsw;
	logic signed [16:0] vel_o, vmin, vmax;
	logic               set_pos_o, busy_o, homed_o, err_o;
	logic signed [31:0] set_pos_val_o, sp_val, sp_pos;
	int                 sp_n, err_total, compares;

	// ****************************************
	// Clock, design and axis
	// ****************************************
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	homing_without_index uut (.clk_i(clk_i), .rstn_i(rstn_i),
		.par_addr_i(addr), .par_wdata_i(wdata), .par_wr_i(wr),
		.par_rd_i(rd), .par_rdata_o(par_rdata_o),
		.homing_method_select_i(meth), .switch_search_speed_i(16'h000a),
		.leave_switch_speed_i(16'h0002), .max_ramp_speed_i(16'h0008),
		.reference_position_value_i(refval), .start_i(start),
		.negative_limit_switch_i(nsw), .positive_limit_switch_i(psw),
		.reference_switch_i(rsw), .pos_i(pos), .motor_still_i(still),
		.vel_o(vel_o), .set_pos_o(set_pos_o), .set_pos_val_o(set_pos_val_o),
		.busy_o(busy_o), .homed_o(homed_o), .err_o(err_o));

	axis_model ax (.clk_i(clk_i), .rstn_i(rstn_i), .vel_i(vel_o),
		.place_i(place), .pos_o(pos), .still_o(still), .neg_sw_o(nsw),
		.pos_sw_o(psw), .ref_sw_o(rsw));

	// Velocity extremes and reference loads of one run
	always @(posedge clk_i) begin
		if (busy_o === 1'b1) begin
			if (vel_o < vmin) vmin <= vel_o;
			if (vel_o > vmax) vmax <= vel_o;
		end
		if (set_pos_o === 1'b1) begin
			sp_n   <= sp_n + 1;
			sp_val <= set_pos_val_o;
			sp_pos <= pos;
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic rd_chk(input string n, input logic [15:0] a,
		input logic [31:0] e);
		addr = a;
		rd = 1'b1;
		@(negedge clk_i);
		rd = 1'b0;
		@(negedge clk_i);
		check(n, e, par_rdata_o);
	endtask

	task automatic home(input logic [15:0] m, input logic ok);
		int n;
		n = 0;
		meth = m;
		place = 1'b1;
		@(negedge clk_i);
		place = 1'b0;
		start = 1'b1;
		vmin = '0;
		vmax = '0;
		sp_n = 0;
		@(negedge clk_i);
		start = 1'b0;
		@(negedge clk_i);
		while (busy_o === 1'b1 && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 4000) begin
			err_total++;
			$display("CHECK FAILED homing timeout expected idle seen busy");
			stop_test();
		end
		// Reference load pulse is counted one edge after busy drops
		@(negedge clk_i);
		check("error flag", 32'(!ok), 32'(err_o));
		check("homed flag", 32'(ok), 32'(homed_o));
		check("reference loads", 32'(ok), sp_n);
		check("velocity at end", '0, 32'(vel_o));
		if (ok)
			check("reference value", refval, sp_val);
		$display("Test method %0d done", m);
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (12) @(negedge clk_i);
		rstn_i = 1'b1;
		@(negedge clk_i);
		check("busy after reset", '0, 32'(busy_o));
		rd_chk("edge limit reset", ADDR_EDGE_LIM, RST_EDGE_LIM);
		rd_chk("offset reset", ADDR_OFFSET, RST_OFFSET);
		rd_chk("overrun reset", ADDR_OVR_LIM, RST_OVR_LIM);
		wr_reg(ADDR_OFFSET, 32'h0);
		rd_chk("offset zero", ADDR_OFFSET, RST_OFFSET);
		wr_reg(ADDR_EDGE_LIM, 32'h8000_0000);
		rd_chk("edge limit sign", ADDR_EDGE_LIM, 32'h0);
		wr_reg(ADDR_EDGE_LIM, 32'h7fff_ffff);
		rd_chk("edge limit max", ADDR_EDGE_LIM, 32'h7fff_ffff);
		wr_reg(ADDR_OFFSET, 32'h32);
		rd_chk("unmapped read", 16'h2800, 32'h0);
		$display("Test registers done");
		home(M_NEG_LIMIT, 1'b1);
		check("search speed", -8, vmin);
		check("leave speed", 2, vmax);
		check("final place", 1, sp_pos >= -950 && sp_pos <= -920);
		rd_chk("status homed", ADDR_STATUS, 32'h2);
		home(M_POS_LIMIT, 1'b1);
		check("search speed up", 8, vmax);
		check("leave speed down", -2, vmin);
		wr_reg(ADDR_EDGE_LIM, 32'h0);
		for (logic [15:0] m = 16'h0017; m <= 16'h001e; m++) begin
			home(m, 1'b1);
			check("search peak", 8, m < 16'h001b ? vmax : -vmin);
		end
		home(16'h0014, 1'b0);
		home(16'h001f, 1'b0);
		wr_reg(ADDR_OVR_LIM, 32'h5);
		home(16'h001b, 1'b0);
		wr_reg(ADDR_OVR_LIM, 32'h0);
		wr_reg(ADDR_EDGE_LIM, 32'h5);
		home(M_NEG_LIMIT, 1'b0);
		rd_chk("status error", ADDR_STATUS, 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire
